//--- rtl/kwdt_pkg.sv
// kwdt_pkg: constants and types shared by the keyed watchdog files
// assumes an 8-bit peripheral register bus with a 16-bit byte address
package kwdt_pkg;
   // register addresses
   localparam logic [15:0] KWDT_ADDR_COUNT = 16'h7023;
   localparam logic [15:0] KWDT_ADDR_KEY = 16'h7025;
   localparam logic [15:0] KWDT_ADDR_CTRL = 16'h7029;
   // service key values
   localparam logic [7:0] KWDT_KEY_ARM = 8'h55;
   localparam logic [7:0] KWDT_KEY_CLEAR = 8'hAA;
   // control register field positions
   localparam int KWDT_CTRL_FLAG_BIT = 7;
   localparam int KWDT_CTRL_DIS_BIT = 6;
   localparam int KWDT_CTRL_CHK_HI = 5;
   localparam int KWDT_CTRL_CHK_LO = 3;
   localparam int KWDT_CTRL_PS_HI = 2;
   localparam int KWDT_CTRL_PS_LO = 0;
   // expected integrity pattern and reset values
   localparam logic [2:0] KWDT_CHK_PATTERN = 3'h5;
   localparam logic [2:0] KWDT_CHK_READ = 3'h0;
   localparam logic [2:0] KWDT_PS_RESET = 3'h0;
   localparam logic [7:0] KWDT_COUNT_RESET = 8'h00;
   localparam logic [7:0] KWDT_RDATA_UNMAPPED = 8'h00;
   // tick divider: cpu clock output divided by 512
   localparam int KWDT_TICK_DIV = 512;
   localparam int KWDT_DIV_W = $clog2(KWDT_TICK_DIV);
   localparam logic [KWDT_DIV_W-1:0] KWDT_DIV_LAST = 9'h1FF;
   localparam int KWDT_PRE_W = 6;
   localparam int KWDT_COUNT_W = 8;

   // register bus request from the cpu
   typedef struct packed {
      logic [15:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } kwdt_bus_req_t;

   // prescaler state
   typedef struct packed {
      logic [KWDT_PRE_W-1:0] pre;
   } kwdt_pre_state_t;

   // main block state
   typedef struct packed {
      logic [KWDT_DIV_W-1:0] div;
      logic tick;
      logic [KWDT_COUNT_W-1:0] count;
      logic ovf_pending;
      logic armed;
      logic flag;
      logic dis;
      logic [2:0] chk;
      logic [2:0] ps;
      logic sys_reset;
      logic [7:0] rdata;
      logic pin_meta;
      logic pin_sync;
      logic cause_seen;
   } kwdt_state_t;
endpackage

//--- rtl/kwdt_prescale.sv
// kwdt_prescale: 6-bit free-running tick prescaler with tap select
// assumes tick is a one-cycle pulse on clk; cleared only by rst
`timescale 1ns/1ps
module kwdt_prescale
   import kwdt_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // tick in, select, counter clock out
   input wire logic tick,
   input wire logic [2:0] sel,
   output logic count_pulse
);
   kwdt_pre_state_t state_reg;
   kwdt_pre_state_t state_next;
   logic [KWDT_PRE_W:0] tap;

   // tap 0 is the raw tick; tap k fires when the low k bits roll over
   assign tap[0] = tick;
   genvar k;
   generate
      for (k = 1; k <= KWDT_PRE_W; k++) begin : g_tap
         assign tap[k] = tick & (&state_reg.pre[k-1:0]);
      end
   endgenerate

   // selection 00x is the raw tick, 010..111 divide by 2..64
   always_comb begin
      state_next = state_reg;
      if (tick) begin
         state_next.pre = state_reg.pre + 6'h01;
      end
      if (sel[2:1] == 2'h0) begin
         count_pulse = tap[0];
      end else begin
         count_pulse = tap[sel - 3'h1];
      end
   end

   // only a system reset clears it; key service never touches it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end
endmodule

//--- rtl/kwdt_top.sv
// kwdt_top: keyed watchdog with tick divider, key logic and control register
// assumes clk is the cpu clock output and the bus request is on clk;
// the disable pin is asynchronous and is synchronised here
`timescale 1ns/1ps
module kwdt_top
   import kwdt_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // cpu status
   input wire logic cpu_suspend,
   input wire logic cpu_halt,
   input wire logic reset_by_wd,
   // external pin
   input wire logic program_supply_pin,
   // register bus
   input wire kwdt_bus_req_t bus_req,
   output logic [7:0] bus_rdata,
   // outputs
   output logic wd_tick_clock,
   output logic sys_reset_out,
   output logic wd_enabled
);
   kwdt_state_t state_reg;
   kwdt_state_t state_next;
   logic count_pulse;
   logic enabled;
   logic key_wr;
   logic ctrl_wr;
   logic bad_key;
   logic wd_event;
   logic [7:0] ctrl_view;

   // counter clock from the prescaler taps
   kwdt_prescale u_prescale (
      .clk(clk),
      .rst(rst),
      .tick(state_reg.tick),
      .sel(state_reg.ps),
      .count_pulse(count_pulse)
   );

   // decode and derived levels
   assign enabled = ~(state_reg.pin_sync & state_reg.dis);
   assign key_wr = bus_req.wr && (bus_req.addr == KWDT_ADDR_KEY);
   assign ctrl_wr = bus_req.wr && (bus_req.addr == KWDT_ADDR_CTRL);
   assign bad_key = key_wr && (bus_req.wdata != KWDT_KEY_ARM)
      && (bus_req.wdata != KWDT_KEY_CLEAR);
   // control view hides the check bits
   assign ctrl_view = {state_reg.flag, state_reg.dis, KWDT_CHK_READ, state_reg.ps};

   // outputs from flip-flops; wd_enabled is gated from pin_sync and dis
   assign bus_rdata = state_reg.rdata;
   assign sys_reset_out = state_reg.sys_reset;
   assign wd_enabled = enabled;
   // tick level shown on the pin only while enabled
   assign wd_tick_clock = state_reg.div[KWDT_DIV_W-1] & enabled;

   always_comb begin
      state_next = state_reg;
      wd_event = 1'b0;

      // pin synchroniser: second stage alone feeds logic
      state_next.pin_meta = program_supply_pin;
      state_next.pin_sync = state_reg.pin_meta;

      // divider frozen in suspend and halt, no register gates it
      state_next.tick = 1'b0;
      if (!cpu_suspend && !cpu_halt) begin
         state_next.div = state_reg.div + 9'h001;
         state_next.tick = (state_reg.div == KWDT_DIV_LAST);
      end

      // counter advances while enabled; wrap marks overflow
      if (count_pulse && enabled) begin
         if (state_reg.ovf_pending) begin
            wd_event = 1'b1;
         end
         state_next.count = state_reg.count + 8'h01;
         if (&state_reg.count) begin
            state_next.ovf_pending = 1'b1;
         end
      end

      // key handling; clear leaves the prescaler alone
      if (key_wr) begin
         if (bus_req.wdata == KWDT_KEY_ARM) begin
            state_next.armed = 1'b1;
         end else if (bus_req.wdata == KWDT_KEY_CLEAR) begin
            if (state_reg.armed) begin
               state_next.count = KWDT_COUNT_RESET;
               state_next.ovf_pending = 1'b0;
               state_next.armed = 1'b0;
            end
         end else begin
            wd_event = 1'b1;
         end
      end

      // control register writes
      if (ctrl_wr) begin
         if (bus_req.wdata[KWDT_CTRL_FLAG_BIT]) begin
            state_next.flag = 1'b0;
         end
         if (state_reg.pin_sync) begin
            state_next.dis = bus_req.wdata[KWDT_CTRL_DIS_BIT];
         end
         state_next.chk = bus_req.wdata[KWDT_CTRL_CHK_HI:KWDT_CTRL_CHK_LO];
         // a bad pattern in the write resets at once, not a cycle later
         if (bus_req.wdata[KWDT_CTRL_CHK_HI:KWDT_CTRL_CHK_LO] != KWDT_CHK_PATTERN) begin
            wd_event = 1'b1;
         end
         state_next.ps = bus_req.wdata[KWDT_CTRL_PS_HI:KWDT_CTRL_PS_LO];
      end

      // integrity check runs every cycle, so corruption is caught too
      if (state_reg.chk != KWDT_CHK_PATTERN) begin
         wd_event = 1'b1;
      end

      // strap-like cause input caught once after reset release
      if (!state_reg.cause_seen) begin
         state_next.cause_seen = 1'b1;
         if (reset_by_wd) begin
            state_next.flag = 1'b1;
         end
      end

      // event sets flag and reset regardless of old flag; set beats clear
      if (wd_event) begin
         state_next.flag = 1'b1;
         state_next.sys_reset = 1'b1;
      end

      // registered read data; counter readable any time
      if (bus_req.rd) begin
         if (bus_req.addr == KWDT_ADDR_COUNT) begin
            state_next.rdata = state_reg.count;
         end else if (bus_req.addr == KWDT_ADDR_KEY) begin
            state_next.rdata = ctrl_view;
         end else if (bus_req.addr == KWDT_ADDR_CTRL) begin
            state_next.rdata = ctrl_view;
         end else begin
            state_next.rdata = KWDT_RDATA_UNMAPPED;
         end
      end
   end

   // state register; counting starts right after release
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= '0;
         state_reg.count <= KWDT_COUNT_RESET;
         state_reg.ps <= KWDT_PS_RESET;
         state_reg.chk <= KWDT_CHK_PATTERN;
      end else begin
         state_reg <= state_next;
      end
   end
endmodule

//--- test/kwdt_chk.sv
// kwdt_chk: port assertions for the keyed watchdog
// assumes a bind to kwdt_top; rst is async, active high
`timescale 1ns/1ps
module kwdt_chk
   import kwdt_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // watched ports
   input wire logic cpu_suspend,
   input wire logic cpu_halt,
   input wire logic program_supply_pin,
   input wire kwdt_bus_req_t bus_req,
   input wire logic [7:0] bus_rdata,
   input wire logic wd_tick_clock,
   input wire logic sys_reset_out,
   input wire logic wd_enabled
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   // bus decodes
   wire logic [15:0] a = bus_req.addr;
   wire logic key_wr = bus_req.wr && a == KWDT_ADDR_KEY;
   wire logic ctl_wr = bus_req.wr && a == KWDT_ADDR_CTRL;
   AST_RESET_HOLDS: assert property (sys_reset_out |=> sys_reset_out)
      else $error("reset output dropped");
   AST_BAD_KEY: assert property (key_wr && !(bus_req.wdata inside {8'h55, 8'hAA})
      |=> sys_reset_out) else $error("bad key gave no reset");
   AST_CHECK_BITS: assert property (ctl_wr && bus_req.wdata[5:3] != KWDT_CHK_PATTERN
      |=> sys_reset_out) else $error("bad check bits gave no reset");
   AST_CHECK_READ: assert property (bus_req.rd && a == KWDT_ADDR_CTRL
      |=> bus_rdata[5:3] == KWDT_CHK_READ) else $error("check bits read nonzero");
   // a stale key would show 010 or 101 in these bits
   AST_KEY_READ: assert property (bus_req.rd && a == KWDT_ADDR_KEY
      |=> bus_rdata[5:3] == KWDT_CHK_READ) else $error("key read not control");
   AST_TICK_GATED: assert property (!wd_enabled ##1 !wd_enabled |-> !wd_tick_clock)
      else $error("tick visible while disabled");
   AST_PIN_LOW: assert property (!program_supply_pin [*4] |-> wd_enabled)
      else $error("disabled without pin");
   AST_STALL: assert property (((cpu_suspend || cpu_halt) && wd_enabled) [*3]
      |-> $stable(wd_tick_clock)) else $error("tick moved while stalled");
   AST_RESET_STATE: assert property ($past(rst) |-> wd_enabled && !sys_reset_out)
      else $error("not enabled after reset");
endmodule
bind kwdt_top kwdt_chk chk_i (.clk, .rst, .cpu_suspend, .cpu_halt, .program_supply_pin,
   .bus_req, .bus_rdata, .wd_tick_clock, .sys_reset_out, .wd_enabled);

//--- test/kwdt_cpu_model.sv
// kwdt_cpu_model: cpu side of the 8-bit peripheral register bus
// assumes the block samples on rising clk; this side moves on falling clk
`timescale 1ns/1ps
module kwdt_cpu_model
   import kwdt_pkg::*;
(
   // clock
   input wire logic clk,
   // register bus
   output kwdt_bus_req_t bus_req,
   input wire logic [7:0] bus_rdata
);
   initial bus_req = '0;
   // one-cycle strobe; idle fields flip so a stale value never matches
   task automatic access(input logic w, input logic [15:0] a, input logic [7:0] d);
      @(negedge clk);
      bus_req <= '{addr: a, wr: w, rd: !w, wdata: d};
      @(negedge clk);
      bus_req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      access(1'b1, a, d);
   endtask
   // read data is registered, so take it a cycle after the strobe
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      access(1'b0, a, 8'h00);
      @(negedge clk);
      d = bus_rdata;
   endtask
endmodule

//--- test/test_kwdt_top.sv
// test_kwdt_top: directed bench for the keyed watchdog
// assumes the cpu model owns the bus; other inputs change on falling clk
`timescale 1ns/1ps
module test_kwdt_top
   import kwdt_pkg::*;
;
   logic clk, rst, cpu_suspend, cpu_halt, reset_by_wd, program_supply_pin;
   logic wd_tick_clock, sys_reset_out, wd_enabled;
   logic [7:0] bus_rdata, rv;
   logic [7:0] keys [4] = '{8'hAA, 8'h55, 8'h55, 8'hAA};
   kwdt_bus_req_t bus_req;
   int error_cnt = 0, check_count = 0, cyc = 0;
   // design and cpu side of the bus
   kwdt_top uut (.clk, .rst, .cpu_suspend, .cpu_halt, .reset_by_wd, .program_supply_pin,
      .bus_req, .bus_rdata, .wd_tick_clock, .sys_reset_out, .wd_enabled);
   kwdt_cpu_model cpu (.clk, .bus_req, .bus_rdata);
   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // hang guard, well above the roughly 6350 cycles needed
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         test_done();
      end
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rdchk(input string what, input logic [15:0] a, input logic [7:0] exp);
      cpu.rd(a, rv);
      chk(what, exp, rv);
   endtask
   task automatic clks(input int n);
      repeat (n) @(negedge clk);
   endtask
   // reset_by_wd stays put so the first edge after release sees it
   task automatic do_reset(input logic cause);
      @(negedge clk);
      rst = 1'b1;
      reset_by_wd = cause;
      clks(6);
      rst = 1'b0;
   endtask
   // reset values, read-only counter, every prescale code
   task automatic t_regs();
      rdchk("ctrl", KWDT_ADDR_CTRL, 8'h00);
      cpu.wr(KWDT_ADDR_COUNT, 8'h77);
      rdchk("count", KWDT_ADDR_COUNT, 8'h00);
      rdchk("unmapped", 16'h7020, KWDT_RDATA_UNMAPPED);
      for (int p = 0; p < 8; p++) begin
         cpu.wr(KWDT_ADDR_CTRL, {5'h05, p[2:0]});
         rdchk("key as ctrl", KWDT_ADDR_KEY, {5'h00, p[2:0]});
      end
      cpu.wr(KWDT_ADDR_CTRL, 8'h28);
      $display("t_regs done");
   endtask
   // counting, stalls, then a clear midway between ticks keeps divider phase
   task automatic t_count();
      clks(1200);
      rdchk("count run", KWDT_ADDR_COUNT, 8'h02);
      cpu_suspend = 1'b1;
      clks(2048);
      rdchk("count susp", KWDT_ADDR_COUNT, 8'h02);
      cpu_suspend = 1'b0;
      cpu_halt = 1'b1;
      clks(2048);
      rdchk("count halt", KWDT_ADDR_COUNT, 8'h02);
      cpu_halt = 1'b0;
      clks(20);
      foreach (keys[i]) cpu.wr(KWDT_ADDR_KEY, keys[i]);
      rdchk("count clr", KWDT_ADDR_COUNT, 8'h00);
      chk("no reset", 8'h00, {7'h00, sys_reset_out});
      clks(300);
      rdchk("count phase", KWDT_ADDR_COUNT, 8'h01);
      $display("t_count done");
   endtask
   // disable needs pin and bit together
   task automatic t_disable();
      cpu.wr(KWDT_ADDR_CTRL, 8'h68);
      rdchk("dis no pin", KWDT_ADDR_CTRL, 8'h00);
      program_supply_pin = 1'b1;
      clks(4);
      cpu.wr(KWDT_ADDR_CTRL, 8'h68);
      rdchk("dis pin", KWDT_ADDR_CTRL, 8'h40);
      chk("disabled", 8'h00, {7'h00, wd_enabled});
      clks(600);
      chk("tick off", 8'h00, {7'h00, wd_tick_clock});
      cpu.wr(KWDT_ADDR_CTRL, 8'h28);
      program_supply_pin = 1'b0;
      chk("enabled", 8'h01, {7'h00, wd_enabled});
      $display("t_disable done");
   endtask
   // bad key, flag handling, check bits
   task automatic t_faults();
      cpu.wr(KWDT_ADDR_KEY, 8'h23);
      clks(1);
      chk("bad key", 8'h01, {7'h00, sys_reset_out});
      do_reset(1'b1);
      rdchk("flag set", KWDT_ADDR_CTRL, 8'h80);
      cpu.wr(KWDT_ADDR_CTRL, 8'h28);
      rdchk("flag kept", KWDT_ADDR_CTRL, 8'h80);
      cpu.wr(KWDT_ADDR_KEY, 8'h12);
      clks(1);
      chk("flag no block", 8'h01, {7'h00, sys_reset_out});
      do_reset(1'b1);
      cpu.wr(KWDT_ADDR_CTRL, 8'hA8);
      rdchk("flag clr", KWDT_ADDR_CTRL, 8'h00);
      cpu.wr(KWDT_ADDR_CTRL, 8'h10);
      clks(1);
      chk("check bits", 8'h01, {7'h00, sys_reset_out});
      $display("t_faults done");
   endtask
   // main sequence
   initial begin
      rst = 1'b1;
      cpu_suspend = 1'b0;
      cpu_halt = 1'b0;
      reset_by_wd = 1'b0;
      program_supply_pin = 1'b0;
      do_reset(1'b0);
      t_regs();
      t_count();
      t_disable();
      t_faults();
      test_done();
   end
endmodule
